//--- testbench/test_arcc_ctrl.sv
// test_arcc_ctrl.sv: self-checking bench for the third regulator control
// assumes: arcc_pkg is compiled first; assertions sit in the design itself
`timescale 1ns/1ps

module test_arcc_ctrl;
    import arcc_pkg::*;

    // ********************************
    // row table and stimulus signals
    // ********************************
    typedef struct packed {
        logic       fresh;
        logic [3:0] ctrl;
        logic [2:0] mode;
        logic [2:0] sense;
        logic       en;
        logic [2:0] stat;
        logic [1:0] cfg;
    } arcc_row_t;

    // modes: 0 init 1 normal 2 stop 3 sleep 4 restart 5 fail-safe
    localparam arcc_row_t ROWS [0:19] = '{
        '{1'b1, 4'h8, 3'h1, 3'h0, 1'b1, 3'h0, 2'h1},
        '{1'b0, 4'h0, 3'h2, 3'h0, 1'b1, 3'h0, 2'h1},
        '{1'b0, 4'h0, 3'h3, 3'h0, 1'b1, 3'h0, 2'h1},
        '{1'b0, 4'h0, 3'h4, 3'h0, 1'b1, 3'h0, 2'h1},
        '{1'b0, 4'h0, 3'h5, 3'h0, 1'b0, 3'h0, 2'h1},
        '{1'b0, 4'h0, 3'h0, 3'h0, 1'b0, 3'h0, 2'h1},
        '{1'b0, 4'h0, 3'h1, 3'h4, 1'b1, 3'h4, 2'h1},
        '{1'b0, 4'h0, 3'h1, 3'h2, 1'b1, 3'h2, 2'h1},
        '{1'b0, 4'h0, 3'h1, 3'h1, 1'b0, 3'h0, 2'h1},
        '{1'b1, 4'h4, 3'h1, 3'h0, 1'b1, 3'h0, 2'h2},
        '{1'b0, 4'h0, 3'h2, 3'h0, 1'b0, 3'h0, 2'h2},
        '{1'b0, 4'h0, 3'h1, 3'h0, 1'b1, 3'h0, 2'h2},
        '{1'b0, 4'h0, 3'h3, 3'h0, 1'b0, 3'h0, 2'h2},
        '{1'b0, 4'h0, 3'h4, 3'h0, 1'b1, 3'h0, 2'h2},
        '{1'b0, 4'h0, 3'h5, 3'h0, 1'b0, 3'h0, 2'h2},
        '{1'b0, 4'h0, 3'h1, 3'h4, 1'b1, 3'h0, 2'h2},
        '{1'b0, 4'h0, 3'h1, 3'h2, 1'b1, 3'h0, 2'h2},
        '{1'b0, 4'h0, 3'h1, 3'h1, 1'b0, 3'h0, 2'h2},
        '{1'b1, 4'h6, 3'h2, 3'h0, 1'b1, 3'h0, 2'h2},
        '{1'b1, 4'h9, 3'h1, 3'h1, 1'b1, 3'h0, 2'h1}
    };

    logic        clk_sys_in    = 1'b0;
    logic        rst_in        = 1'b1;
    arcc_ctrl_t  ctrl_in       = '0;
    logic        ctrl_write_in = 1'b0;
    logic [3:0]  clr           = 4'h0; // oc, uv, err, soft reset
    logic [2:0]  chip_mode_in  = 3'h0;
    arcc_sense_t sense_in      = '0;
    logic        reg_enable_out;
    logic        current_limit_out;
    arcc_cfg_t   cfg_out;
    arcc_stat_t  stat_out;
    int          bad_count     = 0;
    int          check_count   = 0;

    arcc_ctrl u_arcc_ctrl (
        .clk_sys_in        (clk_sys_in),
        .rst_in            (rst_in),
        .ctrl_in           (ctrl_in),
        .ctrl_write_in     (ctrl_write_in),
        .oc_clear_in       (clr[3]),
        .uv_clear_in       (clr[2]),
        .err_clear_in      (clr[1]),
        .soft_reset_in     (clr[0]),
        .chip_mode_in      (chip_mode_in),
        .sense_in          (sense_in),
        .reg_enable_out    (reg_enable_out),
        .current_limit_out (current_limit_out),
        .cfg_out           (cfg_out),
        .stat_out          (stat_out)
    );

    // 8 ns clock
    initial begin
        forever #4 clk_sys_in = ~clk_sys_in;
    end

    // ********************************
    // shared tasks
    // ********************************
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask

    task automatic chk(input logic [2:0] exp, input logic [2:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] c);
        ctrl_in = arcc_ctrl_t'(c);
        ctrl_write_in = 1'b1;
        tick(1);
        ctrl_write_in = 1'b0;
    endtask

    task automatic pulse(input logic [3:0] m);
        clr = m;
        tick(1);
        clr = 4'h0;
    endtask

    // power-on reset, normal mode, then the locking write
    task automatic pwr_up(input logic [3:0] c);
        rst_in = 1'b1;
        chip_mode_in = 3'h1;
        sense_in = '0;
        tick(12);
        rst_in = 1'b0;
        tick(3);
        wr(c);
        tick(2);
    endtask

    task automatic final_report;
        if (bad_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ********************************
    // main sequence
    // ********************************
    initial begin
        foreach (ROWS[i]) begin
            if (ROWS[i].fresh) begin
                pwr_up(ROWS[i].ctrl);
            end
            chip_mode_in = ROWS[i].mode;
            sense_in = arcc_sense_t'(ROWS[i].sense);
            tick(5);
            chk({2'b0, ROWS[i].en}, {2'b0, reg_enable_out});
            chk(ROWS[i].stat, stat_out);
            chk({2'b0, ROWS[i].stat[2]}, {2'b0, current_limit_out});
            chk({1'b0, ROWS[i].cfg}, {1'b0, cfg_out});
            sense_in = '0;
            tick(4);
            pulse(4'he);
        end
        // stand-alone lock: reconfig ignored quietly, on/off still obeyed
        pwr_up(4'h8);
        wr(4'h4);
        tick(2);
        chk(3'h1, {1'b0, cfg_out});
        chk(3'h0, stat_out);
        wr(4'h0);
        tick(2);
        chk(3'h0, {2'b0, reg_enable_out});
        wr(4'h8);
        tick(2);
        chk(3'h1, {2'b0, reg_enable_out});
        pulse(4'h1);
        tick(2);
        chk(3'h1, {1'b0, cfg_out});
        chk(3'h0, {2'b0, reg_enable_out});
        // overcurrent clear refused while the condition stays
        sense_in = 3'h4;
        wr(4'h8);
        tick(5);
        pulse(4'h8);
        tick(1);
        chk(3'h4, stat_out);
        sense_in = '0;
        tick(4);
        chk(3'h4, stat_out);
        chk(3'h0, {2'b0, current_limit_out});
        pulse(4'h8);
        tick(1);
        chk(3'h0, stat_out);
        // load-share lock: back-to-back illegal writes flag an error
        // output level is chosen elsewhere; this write selects no level
        pwr_up(4'h4);
        ctrl_in = arcc_ctrl_t'(4'h8);
        ctrl_write_in = 1'b1;
        tick(1);
        ctrl_in = arcc_ctrl_t'(4'h0);
        tick(1);
        ctrl_write_in = 1'b0;
        tick(1);
        chk(3'h2, {1'b0, cfg_out});
        chk(3'h1, stat_out);
        pulse(4'h2);
        tick(1);
        chk(3'h0, stat_out);
        // loss of supply releases the lock
        rst_in = 1'b1;
        tick(2);
        chk(3'h0, {1'b0, cfg_out});
        chk(3'h0, stat_out);
        chk(3'h0, {2'b0, reg_enable_out});
        // unused regulator: no write after power-up keeps it off
        rst_in = 1'b0;
        tick(3);
        chk(3'h0, {2'b0, reg_enable_out});
        chk(3'h0, {1'b0, cfg_out});
        // stand-alone selection outside normal mode is refused
        chip_mode_in = 3'h2;
        tick(3);
        wr(4'h8);
        tick(2);
        chk(3'h0, {1'b0, cfg_out});
        chk(3'h0, {2'b0, reg_enable_out});
        final_report();
    end

    // watchdog well beyond the expected run length
    initial begin
        #100000;
        bad_count++;
        final_report();
    end

endmodule

//--- verilog/arcc_ctrl.sv
// arcc_ctrl.sv: configuration lock, enable and flags of the third regulator
// assumes: ctrl bits arrive with ctrl_write_in from same-clock serial logic;
// sense inputs are asynchronous; rst_in is the power-on reset only
//
// Operation
// - stand-alone lock keeps only on/off control
// - stand-alone reconfig ignored, no error flag
// - shunt threshold limits current, sets overcurrent
// - overcurrent flag cleared only when condition gone
// - stand-alone undervoltage sets undervoltage flag
// - load-share lock; later change sets error
// - stop without keep disables sharing temporarily
// - sharing active normal; stop if keep set
// - load-share gives no undervoltage indication
// - load-share regulator off in fail-safe
// - load-share never limits nor flags overcurrent
// - input undervoltage switches off unless keep bit
// - lock survives soft reset, cleared by power loss
`timescale 1ns/1ps
`include "arcc_defs.svh"

module arcc_ctrl (
    // clock and power-on reset
    input  wire logic               clk_sys_in,
    input  wire logic               rst_in,
    // serial register writes
    input  wire arcc_pkg::arcc_ctrl_t ctrl_in,
    input  wire logic               ctrl_write_in,
    input  wire logic               oc_clear_in,
    input  wire logic               uv_clear_in,
    input  wire logic               err_clear_in,
    input  wire logic               soft_reset_in,
    // chip mode and sensing
    input  wire logic [2:0]         chip_mode_in,
    input  wire arcc_pkg::arcc_sense_t sense_in,
    // regulator control and status
    output logic                    reg_enable_out,
    output logic                    current_limit_out,
    output arcc_pkg::arcc_cfg_t     cfg_out,
    output arcc_pkg::arcc_stat_t    stat_out
);
    import arcc_pkg::*;

    // ************************************************************
    // input synchronisers
    // ************************************************************
    arcc_sense_t sense_meta;
    arcc_sense_t sense_sync;
    logic [2:0]  mode_meta;
    logic [2:0]  mode_sync;

    // two flops on every asynchronous input
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            sense_meta <= '0;
            sense_sync <= '0;
            mode_meta  <= `ARCC_MODE_INIT;
            mode_sync  <= `ARCC_MODE_INIT;
        end else begin
            sense_meta <= sense_in;
            sense_sync <= sense_meta;
            mode_meta  <= chip_mode_in;
            mode_sync  <= mode_meta;
        end
    end

    // ************************************************************
    // configuration lock
    // ************************************************************
    arcc_cfg_t  cfg;
    arcc_cfg_t  next_cfg;
    logic       sa_on;
    logic       ks_stop;
    logic       keep_uv;
    logic       try_sa;
    logic       try_ls;
    logic       ls_change;
    logic       is_normal;

    assign is_normal = (mode_sync == `ARCC_MODE_NORMAL);
    assign try_ls    = ctrl_write_in && ctrl_in.load_share_select;
    assign try_sa    = ctrl_write_in && ctrl_in.standalone_enable
                       && !ctrl_in.load_share_select && is_normal;
    // any write that departs from pure load-share is a change attempt
    assign ls_change = ctrl_write_in && (cfg == ARCC_CFG_LS_S)
                       && (ctrl_in.standalone_enable
                           || !ctrl_in.load_share_select);

    // first selection locks; later writes cannot move it
    always_comb begin
        next_cfg = cfg;
        case (cfg)
            ARCC_CFG_NONE_S: begin
                if (try_ls)
                    next_cfg = ARCC_CFG_LS_S;
                else if (try_sa)
                    next_cfg = ARCC_CFG_SA_S;
            end
            ARCC_CFG_SA_S:   next_cfg = cfg;
            ARCC_CFG_LS_S:   next_cfg = cfg;
            default:         next_cfg = ARCC_CFG_NONE_S;
        endcase
    end

    // lock held through soft reset, cleared only by power-on reset
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in)
            cfg <= ARCC_CFG_NONE_S;
        else
            cfg <= next_cfg;
    end

    // ************************************************************
    // software bits: on/off, keep-in-stop, keep below input uv
    // ************************************************************
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            sa_on   <= 1'b0;
            ks_stop <= 1'b0;
            keep_uv <= 1'b0;
        end else if (soft_reset_in) begin
            sa_on   <= 1'b0;
            ks_stop <= 1'b0;
            keep_uv <= 1'b0;
        end else if (ctrl_write_in) begin
            // on/off stays usable after stand-alone lock
            sa_on   <= ctrl_in.standalone_enable
                       && (next_cfg == ARCC_CFG_SA_S);
            ks_stop <= ctrl_in.load_share_keep_in_stop;
            keep_uv <= ctrl_in.keep_on_below_input_uv;
        end
    end

    // ************************************************************
    // regulator enable
    // ************************************************************
    logic ls_mode_on;
    logic sa_mode_on;
    logic uv_off;
    logic next_enable;

    // load-share follows chip mode
    assign ls_mode_on = is_normal
        || (mode_sync == `ARCC_MODE_RESTART)
        || ((mode_sync == `ARCC_MODE_STOP) && ks_stop);
    // stand-alone holds its state except in init and fail-safe
    assign sa_mode_on = sa_on
        && (mode_sync != `ARCC_MODE_INIT)
        && (mode_sync != `ARCC_MODE_FAILSAFE);
    assign uv_off = sense_sync.input_supply_undervoltage && !keep_uv;
    assign next_enable = !uv_off && (
        ((cfg == ARCC_CFG_LS_S) && ls_mode_on)
        || ((cfg == ARCC_CFG_SA_S) && sa_mode_on));

    // ************************************************************
    // status flags, set wins over clear
    // ************************************************************
    logic oc_cond;
    logic uv_cond;
    logic oc_flag;
    logic uv_flag;
    logic err_flag;

    // limiting only acts in stand-alone
    assign oc_cond = (cfg == ARCC_CFG_SA_S) && reg_enable_out
                     && sense_sync.shunt_at_threshold;
    assign uv_cond = (cfg == ARCC_CFG_SA_S) && reg_enable_out
                     && sense_sync.aux_output_low;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            oc_flag  <= 1'b0;
            uv_flag  <= 1'b0;
            err_flag <= 1'b0;
        end else begin
            oc_flag  <= oc_cond || (oc_flag && !oc_clear_in);
            uv_flag  <= uv_cond || (uv_flag && !uv_clear_in);
            err_flag <= ls_change || (err_flag && !err_clear_in);
        end
    end

    // ************************************************************
    // registered outputs
    // ************************************************************
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            reg_enable_out    <= 1'b0;
            current_limit_out <= 1'b0;
        end else begin
            reg_enable_out    <= next_enable;
            current_limit_out <= oc_cond;
        end
    end

    assign cfg_out  = cfg;
    assign stat_out = '{aux_overcurrent_flag:  oc_flag,
                        aux_undervoltage_flag: uv_flag,
                        serial_cmd_error:      err_flag};

    // ************************************************************
    // assertions
    // ************************************************************
    a_lock_holds: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (cfg != ARCC_CFG_NONE_S) |=> (cfg == $past(cfg)))
        else $error("configuration changed after lock");
    a_sa_no_error: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (cfg == ARCC_CFG_SA_S) && ctrl_write_in && !err_flag
        |=> !err_flag)
        else $error("error flag set in stand-alone");
    a_ls_change_err: assert property (@(posedge clk_sys_in)
        disable iff (rst_in)
        ls_change |=> err_flag && (cfg == ARCC_CFG_LS_S))
        else $error("load-share change not flagged");
    a_oc_sticky: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        oc_flag && oc_cond |=> oc_flag)
        else $error("overcurrent flag cleared while present");
    a_oc_sets: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        oc_cond |=> oc_flag && current_limit_out)
        else $error("overcurrent not flagged");
    a_ls_no_oc: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (cfg == ARCC_CFG_LS_S) && !oc_flag |=> !oc_flag)
        else $error("overcurrent in load-share");
    a_ls_no_uv: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (cfg == ARCC_CFG_LS_S) && !uv_flag |=> !uv_flag)
        else $error("undervoltage in load-share");
    a_ls_stop_off: assert property (@(posedge clk_sys_in)
        disable iff (rst_in)
        (cfg == ARCC_CFG_LS_S) && (mode_sync == `ARCC_MODE_STOP) && !ks_stop
        |=> !reg_enable_out)
        else $error("load-share on in stop");
    a_ls_normal_on: assert property (@(posedge clk_sys_in)
        disable iff (rst_in)
        (cfg == ARCC_CFG_LS_S) && is_normal && !uv_off
        |=> reg_enable_out)
        else $error("load-share off in normal");
    a_failsafe_off: assert property (@(posedge clk_sys_in)
        disable iff (rst_in)
        (mode_sync == `ARCC_MODE_FAILSAFE) |=> !reg_enable_out)
        else $error("regulator on in fail-safe");
    a_vsuv_off: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        uv_off |=> !reg_enable_out)
        else $error("regulator on below input uv");
    a_uv_sets: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        uv_cond |=> uv_flag)
        else $error("undervoltage not flagged");
    a_sa_onoff: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (cfg == ARCC_CFG_SA_S) && sa_on && is_normal && !uv_off
        |=> reg_enable_out)
        else $error("stand-alone on not honoured");

endmodule

//--- verilog/arcc_defs.svh
// arcc_defs.svh: named constants for the third regulator control block
// assumes: included by bare name from the package and the design module
`ifndef ARCC_DEFS_SVH
`define ARCC_DEFS_SVH

// chip operating mode codes
`define ARCC_MODE_INIT      3'h0
`define ARCC_MODE_NORMAL    3'h1
`define ARCC_MODE_STOP      3'h2
`define ARCC_MODE_SLEEP     3'h3
`define ARCC_MODE_RESTART   3'h4
`define ARCC_MODE_FAILSAFE  3'h5

// configuration state codes
`define ARCC_CFG_NONE       2'h0
`define ARCC_CFG_STANDALONE 2'h1
`define ARCC_CFG_LOADSHARE  2'h2

`endif

//--- verilog/arcc_pkg.sv
// arcc_pkg.sv: types shared by the third regulator control block
// assumes: arcc_defs.svh is on the include path
`include "arcc_defs.svh"

package arcc_pkg;

    // configuration lock state
    typedef enum logic [1:0] {
        ARCC_CFG_NONE_S  = `ARCC_CFG_NONE,
        ARCC_CFG_SA_S    = `ARCC_CFG_STANDALONE,
        ARCC_CFG_LS_S    = `ARCC_CFG_LOADSHARE
    } arcc_cfg_t;

    // software control bits, written over the serial interface
    typedef struct packed {
        logic standalone_enable;
        logic load_share_select;
        logic load_share_keep_in_stop;
        logic keep_on_below_input_uv;
    } arcc_ctrl_t;

    // analog and supervisor status inputs
    typedef struct packed {
        logic shunt_at_threshold;
        logic aux_output_low;
        logic input_supply_undervoltage;
    } arcc_sense_t;

    // status bits returned to software
    typedef struct packed {
        logic aux_overcurrent_flag;
        logic aux_undervoltage_flag;
        logic serial_cmd_error;
    } arcc_stat_t;

endpackage
